// *** clk_select_regs.vh ***
// register offsets, field positions, reset values and codes for the clock selector
`ifndef CLK_SELECT_REGS_VH
`define CLK_SELECT_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define OFS_OUT_FIVE_SIX    7'h62
`define OFS_OUT_SEVEN_FS    7'h63
`define OFS_AUX_APLL_CFG    7'h64
`define OFS_MAIN_DPLL_CFG   7'h65
`define OFS_ALT_DECODE      7'h66

// ****************************************
// reset values
// ****************************************
`define RST_OUT_FIVE_SIX    8'h84
`define RST_OUT_SEVEN_FS    8'hc6
`define RST_AUX_APLL_CFG    8'h05
`define RST_MAIN_DPLL_CFG   8'h01
`define RST_ALT_DECODE      8'h00

// ****************************************
// field positions
// ****************************************
`define BIT_MF_SYNC_EN      7
`define BIT_F_SYNC_EN       6
`define BIT_MEASURE_MAIN    7
`define BIT_AUX_SRC_MAIN    6
`define BIT_ALT_OUT3        0
`define BIT_ALT_OUT5        1
`define BIT_ALT_OUT6        2
`define BIT_ALT_OUT7        3

// ****************************************
// source select codes
// ****************************************
`define SRC_OFF        5'h00
`define SRC_2K         5'h01
`define SRC_8K         5'h02
`define SRC_SYNTH_A    5'h03
`define SRC_SYNTH_B    5'h04
`define SRC_MAIN_D1    5'h05
`define SRC_MAIN_D2    5'h06
`define SRC_MAIN_D4    5'h07
`define SRC_MAIN_D6    5'h08
`define SRC_MAIN_D8    5'h09
`define SRC_MAIN_D12   5'h0a
`define SRC_MAIN_D16   5'h0b
`define SRC_MAIN_D48   5'h0c
`define SRC_MAIN_D64   5'h0d
`define SRC_AUX_D1     5'h0e
`define SRC_AUX_D2     5'h0f
`define SRC_AUX_D4     5'h10
`define SRC_AUX_D5     5'h11
`define SRC_AUX_D8     5'h12
`define SRC_AUX_D10    5'h13
`define SRC_AUX_D12    5'h14
`define SRC_AUX_D16    5'h15
`define SRC_AUX_D20    5'h16
`define SRC_AUX_D48    5'h17
`define SRC_AUX_D64    5'h18
`define SRC_SEC_D1     5'h19
`define SRC_SEC_D2     5'h1a
`define SRC_SEC_D5     5'h1b
`define SRC_SEC_D10    5'h1c
`define SRC_AUX_REF    5'h1d
`define SRC_MAIN_REF   5'h1e

// ****************************************
// synthesizer frequency codes (aux_freq_field)
// ****************************************
`define FRQ_OFF        4'h0
`define FRQ_77M76      4'h1
`define FRQ_24M576     4'h2
`define FRQ_32M768     4'h3
`define FRQ_37M056     4'h4
`define FRQ_24M704     4'h5
`define FRQ_68M736     4'h6
`define FRQ_44M736     4'h7
`define FRQ_25M248     4'h8
`define FRQ_62M500     4'h9
`define FRQ_30M720     4'ha
`define FRQ_40M000     4'hb
`define FRQ_26M000     4'hc
`define FRQ_UNUSED     4'hf

`endif

// *** glitchless_mux.v ***
// glitch-free switch from one clock source to another
`timescale 1ns/1ps
module glitchless_mux #(
   parameter SEL_W = 5
) (
   // clock and reset
   input  wire             clk_sys_in,
   input  wire             reset_in,
   // selection and sources
   input  wire [SEL_W-1:0] sel_in,
   input  wire [31:0]      src_in,
   // output
   output reg              clk_out
);
   reg [SEL_W-1:0] active;
   reg             armed;

   // drop the old source only while low, pass the new one only after
   // it was seen low: no runt on either side; a stuck-high new source stays low
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         active  <= {SEL_W{1'b0}};
         armed   <= 1'b1;
         clk_out <= 1'b0;
      end else if ((sel_in != active) && !src_in[active]) begin
         active  <= sel_in;
         armed   <= 1'b0;
         clk_out <= 1'b0;
      end else if (!armed) begin
         armed   <= !src_in[active];
         clk_out <= 1'b0;
      end else begin
         clk_out <= src_in[active];
      end
   end
endmodule // glitchless_mux

// *** clk_select.v ***
// output clock frequency selection and synthesizer configuration
`timescale 1ns/1ps
`include "clk_select_regs.vh"
module clk_select #(
   parameter ADDR_W = 7
) (
   // clock and reset
   input  wire              clk_sys_in,
   input  wire              reset_in,
   // register port
   input  wire [ADDR_W-1:0] reg_addr_in,
   input  wire              reg_wr_in,
   input  wire              reg_rd_in,
   input  wire [7:0]        reg_wdata_in,
   output reg  [7:0]        reg_rdata_out,
   output reg               reg_hit_out,
   // clock sources, sampled as levels
   input  wire              tick_2k_in,
   input  wire              tick_8k_in,
   input  wire              digital_synth_a_in,
   input  wire              digital_synth_b_in,
   input  wire [13:0]       main_apll_div_in,
   input  wire [10:0]       aux_apll_div_in,
   input  wire [3:0]        main_apll_second_div_in,
   input  wire              aux_ref_in,
   input  wire              main_ref_in,
   // output clocks
   output wire              clock_out_three,
   output wire              clock_out_five,
   output wire              clock_out_six,
   output wire              clock_out_seven,
   output reg               multiframe_sync_pin_out,
   output reg               frame_sync_pin_out,
   // synthesizer and dpll control
   output reg  [3:0]        aux_synth_freq_out,
   output reg               aux_apll_enable_out,
   output reg               aux_follows_main_out,
   output reg  [3:0]        main_synth_freq_out,
   output reg               aux_measure_main_phase_out,
   // output 3 field, held elsewhere
   input  wire [3:0]        out3_freq_sel_in
);
   // ****************************************
   // registers
   // ****************************************
   reg  [7:0] output_freq_sel_five_six;
   reg  [7:0] output_freq_sel_seven_framesync;
   reg  [7:0] aux_apll_freq_config;
   reg  [7:0] main_dpll_config_one;
   reg  [7:0] alt_decode_register;

   wire [3:0] out5_freq_sel  = output_freq_sel_five_six[3:0];
   wire [3:0] out6_freq_sel  = output_freq_sel_five_six[7:4];
   wire [3:0] out7_freq_sel  = output_freq_sel_seven_framesync[3:0];
   wire [3:0] aux_freq_field = aux_apll_freq_config[3:0];
   wire [2:0] main_to_aux_freq_field = main_dpll_config_one[5:3];
   wire [2:0] main_freq_field        = main_dpll_config_one[2:0];
   wire       aux_apll_source_sel =
              main_dpll_config_one[`BIT_AUX_SRC_MAIN];

   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         output_freq_sel_five_six        <= `RST_OUT_FIVE_SIX;
         output_freq_sel_seven_framesync <= `RST_OUT_SEVEN_FS;
         aux_apll_freq_config            <= `RST_AUX_APLL_CFG;
         main_dpll_config_one            <= `RST_MAIN_DPLL_CFG;
         alt_decode_register             <= `RST_ALT_DECODE;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `OFS_OUT_FIVE_SIX) begin
            output_freq_sel_five_six <= reg_wdata_in;
         end else if (reg_addr_in == `OFS_OUT_SEVEN_FS) begin
            // bits 5:4 reserved, read as zero
            output_freq_sel_seven_framesync <= reg_wdata_in & 8'hcf;
         end else if (reg_addr_in == `OFS_AUX_APLL_CFG) begin
            aux_apll_freq_config <= reg_wdata_in & 8'h0f;
         end else if (reg_addr_in == `OFS_MAIN_DPLL_CFG) begin
            main_dpll_config_one <= reg_wdata_in;
         end else if (reg_addr_in == `OFS_ALT_DECODE) begin
            alt_decode_register <= reg_wdata_in & 8'h0f;
         end
      end
   end

   // read data registered; unmapped offsets read zero with no hit
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         reg_rdata_out <= 8'h00;
         reg_hit_out   <= 1'b0;
      end else begin
         reg_hit_out <= 1'b0;
         if (reg_rd_in && !reg_wr_in) begin  // write wins a collision
            reg_hit_out <= 1'b1;
            if (reg_addr_in == `OFS_OUT_FIVE_SIX) begin
               reg_rdata_out <= output_freq_sel_five_six;
            end else if (reg_addr_in == `OFS_OUT_SEVEN_FS) begin
               reg_rdata_out <= output_freq_sel_seven_framesync;
            end else if (reg_addr_in == `OFS_AUX_APLL_CFG) begin
               reg_rdata_out <= aux_apll_freq_config;
            end else if (reg_addr_in == `OFS_MAIN_DPLL_CFG) begin
               reg_rdata_out <= main_dpll_config_one;
            end else if (reg_addr_in == `OFS_ALT_DECODE) begin
               reg_rdata_out <= alt_decode_register;
            end else begin
               reg_rdata_out <= 8'h00;
               reg_hit_out   <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // decode functions
   // ****************************************
   // common tail 0110-1010: main /16,/12,/8,/6,/4; 1011-1111 aux
   function [4:0] std_tail;
      input [3:0] code;
      begin
         case (code)
            4'h6:    std_tail = `SRC_MAIN_D16;
            4'h7:    std_tail = `SRC_MAIN_D12;
            4'h8:    std_tail = `SRC_MAIN_D8;
            4'h9:    std_tail = `SRC_MAIN_D6;
            4'ha:    std_tail = `SRC_MAIN_D4;
            4'hb:    std_tail = `SRC_AUX_D64;
            4'hc:    std_tail = `SRC_AUX_D48;
            4'hd:    std_tail = `SRC_AUX_D16;
            4'he:    std_tail = `SRC_AUX_D8;
            4'hf:    std_tail = `SRC_AUX_D4;
            default: std_tail = `SRC_OFF;
         endcase
      end
   endfunction

   // alternate decode shared by outputs 6 and 7
   function [4:0] alt_six_seven;
      input [3:0] code;
      begin
         case (code)
            4'h1:    alt_six_seven = `SRC_AUX_D5;
            4'h2:    alt_six_seven = `SRC_AUX_D2;
            4'h3:    alt_six_seven = `SRC_AUX_D1;
            4'h4:    alt_six_seven = `SRC_SEC_D5;
            4'h5:    alt_six_seven = `SRC_SEC_D2;
            4'h6:    alt_six_seven = `SRC_SEC_D1;
            4'h7:    alt_six_seven = `SRC_AUX_REF;
            4'h8:    alt_six_seven = `SRC_MAIN_REF;
            default: alt_six_seven = `SRC_OFF;
         endcase
      end
   endfunction

   reg [4:0] sel3;
   reg [4:0] sel5;
   reg [4:0] sel6;
   reg [4:0] sel7;

   always @* begin
      // output 3: the alternate decode lives in this block; the standard one falls to std_tail for codes 0 and 6-f
      sel3 = `SRC_OFF;
      if (alt_decode_register[`BIT_ALT_OUT3]) begin
         case (out3_freq_sel_in)
            4'h1:    sel3 = `SRC_MAIN_D64;
            4'h2:    sel3 = `SRC_AUX_D20;
            4'h3:    sel3 = `SRC_AUX_D12;
            4'h4:    sel3 = `SRC_AUX_D10;
            4'h5:    sel3 = `SRC_AUX_D5;
            4'h6:    sel3 = `SRC_AUX_D2;
            4'h7:    sel3 = `SRC_AUX_REF;
            4'h8:    sel3 = `SRC_MAIN_REF;
            default: sel3 = `SRC_OFF;
         endcase
      end else begin
         case (out3_freq_sel_in)
            4'h1:    sel3 = `SRC_2K;
            4'h2:    sel3 = `SRC_8K;
            4'h3:    sel3 = `SRC_SYNTH_B;
            4'h4:    sel3 = `SRC_SYNTH_A;
            4'h5:    sel3 = `SRC_MAIN_D48;
            default: sel3 = std_tail(out3_freq_sel_in);
         endcase
      end
      // output 5
      if (alt_decode_register[`BIT_ALT_OUT5]) begin
         case (out5_freq_sel)
            4'h1:    sel5 = `SRC_MAIN_D2;
            4'h2:    sel5 = `SRC_MAIN_D1;
            4'h3:    sel5 = `SRC_AUX_D10;
            4'h4:    sel5 = `SRC_SEC_D10;
            4'h5:    sel5 = `SRC_SEC_D2;
            4'h6:    sel5 = `SRC_SEC_D1;
            4'h7:    sel5 = `SRC_AUX_REF;
            4'h8:    sel5 = `SRC_MAIN_REF;
            default: sel5 = `SRC_OFF;
         endcase
      end else begin
         case (out5_freq_sel)
            4'h1:    sel5 = `SRC_2K;
            4'h2:    sel5 = `SRC_8K;
            4'h3:    sel5 = `SRC_SYNTH_B;
            4'h4:    sel5 = `SRC_SYNTH_A;
            4'h5:    sel5 = `SRC_MAIN_D48;
            4'hb:    sel5 = `SRC_AUX_D2;
            default: sel5 = std_tail(out5_freq_sel);
         endcase
      end
      // output 6
      if (alt_decode_register[`BIT_ALT_OUT6]) begin
         sel6 = alt_six_seven(out6_freq_sel);
      end else begin
         case (out6_freq_sel)
            4'h1:    sel6 = `SRC_2K;
            4'h2:    sel6 = `SRC_8K;
            4'h3:    sel6 = `SRC_MAIN_D2;
            4'h4:    sel6 = `SRC_SYNTH_A;
            4'h5:    sel6 = `SRC_MAIN_D1;
            default: sel6 = std_tail(out6_freq_sel);
         endcase
      end
      // output 7
      if (alt_decode_register[`BIT_ALT_OUT7]) begin
         sel7 = alt_six_seven(out7_freq_sel);
      end else begin
         case (out7_freq_sel)
            4'h1:    sel7 = `SRC_2K;
            4'h2:    sel7 = `SRC_8K;
            4'h3:    sel7 = `SRC_SYNTH_B;
            4'h4:    sel7 = `SRC_MAIN_D2;
            4'h5:    sel7 = `SRC_MAIN_D48;
            default: sel7 = std_tail(out7_freq_sel);
         endcase
      end
   end

   // ****************************************
   // source vector and output muxes
   // ****************************************
   // main div bits: 1,2,4,6,8,12,16,48,64 at [0..8]; others spare
   // aux div bits: 1,2,4,5,8,10,12,16,20,48,64 at [0..10]
   // second main div bits: 1,2,5,10 at [0..3]
   wire        aux_live = aux_apll_enable_out;
   wire [10:0] aux_div  = aux_live ? aux_apll_div_in : 11'h000;
   wire [31:0] src_vec  = {1'b0, main_ref_in, aux_ref_in,
                           main_apll_second_div_in[3],
                           main_apll_second_div_in[2],
                           main_apll_second_div_in[1],
                           main_apll_second_div_in[0],
                           aux_div[10], aux_div[9], aux_div[8],
                           aux_div[7], aux_div[6], aux_div[5],
                           aux_div[4], aux_div[3], aux_div[2],
                           aux_div[1], aux_div[0],
                           main_apll_div_in[8], main_apll_div_in[7],
                           main_apll_div_in[6], main_apll_div_in[5],
                           main_apll_div_in[4], main_apll_div_in[3],
                           main_apll_div_in[2], main_apll_div_in[1],
                           main_apll_div_in[0],
                           digital_synth_b_in, digital_synth_a_in,
                           tick_8k_in, tick_2k_in, 1'b0};

   glitchless_mux #(.SEL_W(5)) mux_three (
      .clk_sys_in (clk_sys_in),
      .reset_in   (reset_in),
      .sel_in     (sel3),
      .src_in     (src_vec),
      .clk_out    (clock_out_three)
   );
   glitchless_mux #(.SEL_W(5)) mux_five (
      .clk_sys_in (clk_sys_in),
      .reset_in   (reset_in),
      .sel_in     (sel5),
      .src_in     (src_vec),
      .clk_out    (clock_out_five)
   );
   glitchless_mux #(.SEL_W(5)) mux_six (
      .clk_sys_in (clk_sys_in),
      .reset_in   (reset_in),
      .sel_in     (sel6),
      .src_in     (src_vec),
      .clk_out    (clock_out_six)
   );
   glitchless_mux #(.SEL_W(5)) mux_seven (
      .clk_sys_in (clk_sys_in),
      .reset_in   (reset_in),
      .sel_in     (sel7),
      .src_in     (src_vec),
      .clk_out    (clock_out_seven)
   );

   // ****************************************
   // frame sync pins and synthesizer control
   // ****************************************
   reg [3:0] next_aux_freq;

   always @* begin
      if (aux_apll_source_sel) begin
         case (main_to_aux_freq_field)
            3'h0:    next_aux_freq = `FRQ_24M576;
            3'h1:    next_aux_freq = `FRQ_62M500;
            3'h2:    next_aux_freq = `FRQ_32M768;
            3'h4:    next_aux_freq = `FRQ_37M056;
            3'h6:    next_aux_freq = `FRQ_24M704;
            3'h7:    next_aux_freq = `FRQ_25M248;
            default: next_aux_freq = `FRQ_UNUSED;
         endcase
      end else if (aux_freq_field > `FRQ_26M000) begin
         next_aux_freq = `FRQ_UNUSED;
      end else begin
         next_aux_freq = aux_freq_field;
      end
   end

   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         multiframe_sync_pin_out    <= 1'b0;
         frame_sync_pin_out         <= 1'b0;
         aux_synth_freq_out         <= `FRQ_OFF;
         aux_apll_enable_out        <= 1'b0;
         aux_follows_main_out       <= 1'b0;
         main_synth_freq_out        <= `FRQ_77M76;
         aux_measure_main_phase_out <= 1'b0;
      end else begin
         multiframe_sync_pin_out <= tick_2k_in &
            output_freq_sel_seven_framesync[`BIT_MF_SYNC_EN];
         frame_sync_pin_out <= tick_8k_in &
            output_freq_sel_seven_framesync[`BIT_F_SYNC_EN];
         aux_synth_freq_out   <= next_aux_freq;
         aux_apll_enable_out  <= (next_aux_freq != `FRQ_OFF) &&
                                 (next_aux_freq != `FRQ_UNUSED);
         aux_follows_main_out <= aux_apll_source_sel;
         case (main_freq_field)
            3'h0:    main_synth_freq_out <= `FRQ_77M76;
            3'h1:    main_synth_freq_out <= `FRQ_77M76;
            3'h2:    main_synth_freq_out <= `FRQ_24M576;
            3'h3:    main_synth_freq_out <= `FRQ_32M768;
            3'h4:    main_synth_freq_out <= `FRQ_37M056;
            3'h5:    main_synth_freq_out <= `FRQ_24M704;
            3'h6:    main_synth_freq_out <= `FRQ_25M248;
            default: main_synth_freq_out <= `FRQ_62M500;
         endcase
         aux_measure_main_phase_out <=
            main_dpll_config_one[`BIT_MEASURE_MAIN];
      end
   end
endmodule // clk_select

// *** clk_select_props.sv ***
// concurrent checks on the clock selector ports
`timescale 1ns/1ps
module clk_select_props #(
   parameter ADDR_W = 7
) (
   // clock and reset
   input wire              clk_sys_in,
   input wire              reset_in,
   // register port
   input wire [ADDR_W-1:0] reg_addr_in,
   input wire              reg_wr_in,
   input wire              reg_rd_in,
   input wire [7:0]        reg_wdata_in,
   input wire [7:0]        reg_rdata_out,
   input wire              reg_hit_out,
   // sources and outputs
   input wire              tick_2k_in,
   input wire              tick_8k_in,
   input wire [3:0]        out3_freq_sel_in,
   input wire              clock_out_three,
   input wire              multiframe_sync_pin_out,
   input wire              frame_sync_pin_out,
   input wire [3:0]        aux_synth_freq_out,
   input wire              aux_apll_enable_out,
   input wire              aux_follows_main_out,
   input wire [3:0]        main_synth_freq_out,
   input wire              aux_measure_main_phase_out
);
   // ****
   // helpers
   // ****
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   wire rd_only = reg_rd_in && !reg_wr_in;
   wire mapped  = reg_addr_in >= 7'h62 && reg_addr_in <= 7'h66;
   sequence s_cfg_write;
      reg_wr_in && reg_addr_in == 7'h65 ##1 !reg_wr_in [*3];
   endsequence
   // off long enough that the switch-over has landed
   sequence s_off3;
      (out3_freq_sel_in == 4'h0) [*4] ##0 !clock_out_three;
   endsequence
   // ****
   // assertions
   // ****
   a_hit_after_read: assert property (
      rd_only && mapped |=> reg_hit_out) else $error("no hit after read");
   a_unmapped_zero: assert property (
      rd_only && !mapped |=> !reg_hit_out && reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_hit_cause: assert property (
      reg_hit_out |-> $past(rd_only) && $past(mapped))
      else $error("hit without read");
   a_rdata_hold: assert property (
      !rd_only |=> $stable(reg_rdata_out)) else $error("read data moved");
   a_mfs_low: assert property (
      !tick_2k_in |=> !multiframe_sync_pin_out) else $error("mf sync high");
   a_fs_low: assert property (
      !tick_8k_in |=> !frame_sync_pin_out) else $error("f sync high");
   a_off_stays_low: assert property (
      s_off3 ##1 out3_freq_sel_in == 4'h0 |-> !clock_out_three)
      else $error("disabled output rose");
   a_ctrl_copy: assert property (
      s_cfg_write |-> {aux_measure_main_phase_out, aux_follows_main_out}
         == $past(reg_wdata_in[7:6], 3)) else $error("control bits wrong");
   a_main_map: assert property (
      main_synth_freq_out inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9})
      else $error("main code outside table");
   a_aux_enable: assert property (
      aux_apll_enable_out == (aux_synth_freq_out != 4'h0
         && aux_synth_freq_out != 4'hf)) else $error("aux enable wrong");
endmodule // clk_select_props

bind clk_select clk_select_props #(.ADDR_W(ADDR_W)) u_props (
   .clk_sys_in, .reset_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
   .reg_wdata_in, .reg_rdata_out, .reg_hit_out, .tick_2k_in, .tick_8k_in,
   .out3_freq_sel_in, .clock_out_three, .multiframe_sync_pin_out,
   .frame_sync_pin_out, .aux_synth_freq_out, .aux_apll_enable_out,
   .aux_follows_main_out, .main_synth_freq_out, .aux_measure_main_phase_out);

// *** tb_clk_select.sv ***
// self-checking bench for the clock selector
`timescale 1ns/1ps
module tb_clk_select;
   // ****
   // stimulus and observation
   // ****
   logic        clk_sys_in = 0;
   logic        reset_in = 1;
   logic [6:0]  reg_addr_in = 0;
   logic        reg_wr_in = 0;
   logic        reg_rd_in = 0;
   logic [7:0]  reg_wdata_in = 0;
   logic [3:0]  out3_freq_sel_in = 0;
   wire  [7:0]  reg_rdata_out;
   wire         reg_hit_out;
   wire  [13:0] mdiv;
   wire  [10:0] adiv;
   wire  [3:0]  sdiv;
   wire  [5:0]  oc;
   wire  [3:0]  afrq, mfrq;
   wire         aen, afol, ameas;
   logic [5:0]  oc_q = 0;
   int          cyc = 0, bad_count = 0, compares = 0, last[6], gap[6];
   // half-period of each source equals its source code, so a period
   // names the source; trades sim time for a one-number check
   logic [127:0] t5s = 128'h1012_1517_0f07_0809_0a0b_0c03_0402_0100;
   logic [127:0] t5a = 128'h0000_0000_0000_001e_1d19_1a1c_1305_0600;
   logic [127:0] t6s = 128'h1012_1517_1807_0809_0a0b_0503_0602_0100;
   logic [127:0] t67a = 128'h0000_0000_0000_001e_1d19_1a1b_0e0f_1100;
   logic [127:0] t7s = 128'h1012_1517_1807_0809_0a0b_0c06_0402_0100;
   logic [127:0] t3a = 128'h0000_0000_0000_001e_1d0f_1113_1416_0d00;
   logic [127:0] t3s = 128'h1012_1517_1807_0809_0a0b_0c03_0402_0100;
   logic [31:0]  t19 = 32'h85f4_f392;
   logic [31:0]  t20 = 32'h9854_3211;
   function automatic logic lvl(input int c, input int h);
      return ((c / h) % 2) == 1;
   endfunction
   for (genvar g = 0; g < 14; g++) begin : g_m
      assign mdiv[g] = lvl(cyc, g < 9 ? 5 + g : 31);
   end
   for (genvar g = 0; g < 11; g++) begin : g_a
      assign adiv[g] = lvl(cyc, 14 + g);
   end
   for (genvar g = 0; g < 4; g++) begin : g_s
      assign sdiv[g] = lvl(cyc, 25 + g);
   end
   clk_select u_dut (
      .clk_sys_in, .reset_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
      .reg_wdata_in, .reg_rdata_out, .reg_hit_out,
      .tick_2k_in(lvl(cyc, 1)), .tick_8k_in(lvl(cyc, 2)),
      .digital_synth_a_in(lvl(cyc, 3)), .digital_synth_b_in(lvl(cyc, 4)),
      .main_apll_div_in(mdiv), .aux_apll_div_in(adiv),
      .main_apll_second_div_in(sdiv), .aux_ref_in(lvl(cyc, 29)),
      .main_ref_in(lvl(cyc, 30)), .clock_out_three(oc[0]),
      .clock_out_five(oc[1]), .clock_out_six(oc[2]), .clock_out_seven(oc[3]),
      .multiframe_sync_pin_out(oc[4]), .frame_sync_pin_out(oc[5]),
      .aux_synth_freq_out(afrq), .aux_apll_enable_out(aen),
      .aux_follows_main_out(afol), .main_synth_freq_out(mfrq),
      .aux_measure_main_phase_out(ameas), .out3_freq_sel_in);
   initial forever #5 clk_sys_in = ~clk_sys_in;
   // sources step and output edges are timed on the falling edge
   always @(negedge clk_sys_in) begin
      cyc <= cyc + 1;
      oc_q <= oc;
      for (int i = 0; i < 6; i++)
         if (oc[i] === 1'b1 && oc_q[i] === 1'b0) begin
            last[i] <= cyc;
            gap[i] <= cyc - last[i];
         end
   end
   // ****
   // tasks
   // ****
   function automatic logic [7:0] per(input int i);
      return (cyc - last[i] > 70) ? 8'h00 : gap[i][7:0];
   endfunction
   function automatic logic [7:0] ent(input logic [127:0] t, input int c);
      return {t[8*c +: 7], 1'b0};
   endfunction
   task automatic chk(input string n, input logic [7:0] e, s);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wreg(input logic [6:0] a, input logic [7:0] d);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1;
      @(negedge clk_sys_in);
      reg_wr_in = 0;
      @(negedge clk_sys_in);
   endtask
   task automatic rreg(input logic [6:0] a, input logic [7:0] e, input h);
      reg_addr_in = a;
      reg_rd_in = 1;
      @(negedge clk_sys_in);
      chk("read data", e, reg_rdata_out);
      chk("hit", {7'h0, h}, {7'h0, reg_hit_out});
      reg_rd_in = 0;
      @(negedge clk_sys_in);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (12000) @(posedge clk_sys_in);
      bad_count++;
      tally_and_finish();
   end
   // ****
   // tests
   // ****
   initial begin
      repeat (20) @(negedge clk_sys_in);
      reset_in = 0;
      rreg(7'h62, 8'h84, 1);
      rreg(7'h63, 8'hc6, 1);
      rreg(7'h64, 8'h05, 1);
      rreg(7'h65, 8'h01, 1);
      rreg(7'h66, 8'h00, 1);
      rreg(7'h67, 8'h00, 0);
      wreg(7'h66, 8'hff);
      rreg(7'h66, 8'h0f, 1);
      wreg(7'h63, 8'hff);
      rreg(7'h63, 8'hcf, 1);
      for (int k = 0; k < 16; k++) begin
         wreg(7'h64, k[7:0]);
         repeat (3) @(negedge clk_sys_in);
         chk("aux", k < 13 ? k[7:0] : 8'h0f, {4'h0, afrq});
         chk("aux on", {7'h0, k > 0 && k < 13}, {7'h0, aen});
      end
      for (int m = 0; m < 8; m++) begin
         wreg(7'h65, {2'b11, m[2:0], m[2:0]});
         repeat (3) @(negedge clk_sys_in);
         chk("aux", {4'h0, t19[4*m +: 4]}, {4'h0, afrq});
         chk("main", {4'h0, t20[4*m +: 4]}, {4'h0, mfrq});
         chk("ctrl", 8'h03, {6'h0, ameas, afol});
      end
      wreg(7'h65, 8'h01);
      chk("ctrl", 8'h00, {6'h0, ameas, afol});
      wreg(7'h64, 8'h05);
      for (int a = 0; a < 2; a++) begin
         wreg(7'h66, {4'h0, {4{a[0]}}});
         for (int c = 0; c < 16; c++) begin
            wreg(7'h62, {c[3:0], c[3:0]});
            wreg(7'h63, {~a[0], ~a[0], 2'b00, c[3:0]});
            out3_freq_sel_in = c[3:0];
            repeat (260) @(negedge clk_sys_in);
            chk("out5", ent(a ? t5a : t5s, c), per(1));
            chk("out6", ent(a ? t67a : t6s, c), per(2));
            chk("out7", ent(a ? t67a : t7s, c), per(3));
            chk("out3", ent(a ? t3a : t3s, c), per(0));
            chk("mf sync", a ? 8'h00 : 8'h02, per(4));
            chk("f sync", a ? 8'h00 : 8'h04, per(5));
         end
      end
      wreg(7'h62, 8'h00);
      reset_in = 1;
      repeat (3) @(negedge clk_sys_in);
      reset_in = 0;
      rreg(7'h62, 8'h84, 1);
      tally_and_finish();
   end
endmodule // tb_clk_select
